/* File: pkg/adc_ctl_pkg.sv */
package adc_ctl_pkg;
   // Instruction word, bit 0 is the first bit shifted in.
   localparam int INSTR_BITS = 8;
   localparam int NUM_CH = 8;
   localparam int NUM_PAIRS = 4;
   localparam int CODE_BITS = 13;
   localparam int STATUS_BITS = 16;
   localparam int STAT_BUSY = 0;
   localparam int STAT_PDOWN = 1;
   localparam int STAT_SIGN = 2;
   localparam int STAT_VALID = 3;
   localparam int STAT_TEST = 9;
   localparam int ACQ_BITS = 6;
   localparam int CNT_BITS = 8;
   // Field positions inside the instruction.
   localparam int DI_TEST_LO = 4;
   localparam int DI_CONV = 4;
   localparam int DI_SINGLE = 0;
   localparam int DI_ODD_POS = 1;
   localparam int DI_PAIR_LO = 2;
   localparam int DI_RES_LO = 5;
   localparam int DI_LSB_FIRST = 7;
   // Fixed instruction codes, written as bits 7 down to 0.
   localparam logic [7:0] OP_RESET = 8'h70;
   localparam logic [7:0] OP_TEST_A = 8'h50;
   localparam logic [7:0] OP_TEST_B = 8'hd0;
   localparam logic [7:0] OP_USER = 8'hf0;
   localparam logic [7:0] OP_PWR_UP = 8'h50;
   localparam logic [7:0] OP_PWR_DN = 8'h90;
   localparam logic [6:0] OP_SIGN_HI = 7'h58;
   localparam logic [5:0] OP_ACQ_HI = 6'h1c;
   localparam logic [3:0] OP_TEST_HI = 4'hf;
   // Acquisition lengths in conversion clock cycles.
   localparam logic [ACQ_BITS-1:0] ACQ_6 = 6'h06;
   localparam logic [ACQ_BITS-1:0] ACQ_10 = 6'h0a;
   localparam logic [ACQ_BITS-1:0] ACQ_18 = 6'h12;
   localparam logic [ACQ_BITS-1:0] ACQ_34 = 6'h22;
   localparam logic [1:0] ACQ_SEL_RST = 2'h1;
   // Resolution codes and output lengths.
   localparam logic [1:0] RES_12 = 2'h0;
   localparam logic [1:0] RES_8 = 2'h1;
   localparam logic [1:0] RES_16 = 2'h2;
   localparam logic [4:0] LEN_8 = 5'h08;
   localparam logic [4:0] LEN_12 = 5'h0c;
   localparam logic [4:0] LEN_16 = 5'h10;
   localparam logic SIGN_RST = 1'b1;
   localparam logic [CODE_BITS-1:0] CODE_ZERO = 13'h0000;
   typedef enum logic [3:0] {
      rec_idle = 4'b0001,
      rec_reset = 4'b0010,
      rec_test_a = 4'b0100,
      rec_test_b = 4'b1000
   } rec_state_t;
   typedef enum logic [2:0] {
      cv_idle = 3'b001,
      cv_acq = 3'b010,
      cv_conv = 3'b100
   } conv_state_t;
endpackage

/* File: design/adc_power_mode_mux_control.sv */
// Overview of operation
// - Power-down stops the converter only; the serial interface keeps working.
// - Power-up instruction cannot wake the device while the pin holds it down.
// - Power-down instruction powers down even when the pin asks for power-up.
// - Software power-down ends on power-up instruction or a high-then-low pin pulse.
// - Power-down during a conversion aborts it; the next result is marked invalid.
// - First bit high with bits four to seven high enters test mode, driving inputs.
// - Status bit 9 reads high in test mode, low in user mode.
// - Reset brings user mode, clearing test mode and serial framing.
// - Reset, two test words, then user word returns to user mode.
// - Convert strobe high during a frame shifts old data, starts nothing.
// - Each conversion picks a differential pair or a single-ended input.
// - Differential use routes even inputs first, odd inputs second.
// - Pairs are fixed as 0-1, 2-3, 4-5 and 6-7.
// - Differential instruction chooses which converter input is positive.
// - Single-ended routes the input first as positive, common reference second.
// - Single-ended results have sign zero, negative readings clamp to zero.
// - Signed results are two's complement from -4096 to +4095.
// - Reset defaults: 12 bits plus sign, MSB first, 10 cycle acquisition, powered up.
`timescale 1ns/1ps
module adc_power_mode_mux_control #(
   parameter int CONV_CYCLES = 44,
   parameter int FRAME_BITS_CONT = 13
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic serial_data_in_i,
   input wire logic conv_n_i,
   input wire logic power_down_pin_i,
   input wire logic signed [adc_ctl_pkg::CODE_BITS-1:0] raw_code_i,
   output logic converter_enable_o,
   output logic busy_o,
   output logic eoc_o,
   output logic result_valid_o,
   output logic [adc_ctl_pkg::CODE_BITS-1:0] result_o,
   output logic [adc_ctl_pkg::STATUS_BITS-1:0] status_o,
   output logic [adc_ctl_pkg::NUM_CH-1:0] selector_output_first_sel_o,
   output logic [adc_ctl_pkg::NUM_PAIRS-1:0] selector_output_second_sel_o,
   output logic selector_output_second_common_o,
   output logic converter_input_first_positive_o,
   output logic [adc_ctl_pkg::NUM_CH-1:0] analog_inputs_o,
   output logic [adc_ctl_pkg::NUM_CH-1:0] analog_inputs_oe_o,
   output logic [4:0] out_bits_o,
   output logic lsb_first_o
);
   import adc_ctl_pkg::*;
   localparam int FCW = $clog2(FRAME_BITS_CONT + 1);
   localparam logic [FCW-1:0] FC_INSTR = FCW'(INSTR_BITS);
   localparam logic [FCW-1:0] FC_LAST = FCW'(FRAME_BITS_CONT - 1);
   localparam logic [CNT_BITS-1:0] CONV_LAST = CNT_BITS'(CONV_CYCLES - 1);
   if (FRAME_BITS_CONT < INSTR_BITS || CONV_CYCLES < 1 || CONV_CYCLES > (1 << CNT_BITS)) begin
      $error("adc_power_mode_mux_control: unsupported parameter value");
   end
   // Serial side, clocked by the link clock. Chip select high clears framing.
   logic [FCW-1:0] bit_cnt_r;
   logic [INSTR_BITS-2:0] shift_r;
   logic [INSTR_BITS-1:0] word_hold_r;
   logic hold_conv_r;
   logic word_tgl_r;
   logic conv_s1_r;
   logic conv_s2_r;
   logic frame_rst;
   assign frame_rst = rst_i | cs_n_i;
   always_ff @(posedge sclk_i or posedge frame_rst) begin
      if (frame_rst) begin
         bit_cnt_r <= '0;
      end else if (bit_cnt_r == FC_LAST) begin
         bit_cnt_r <= '0;
      end else begin
         bit_cnt_r <= bit_cnt_r + FCW'(1);
      end
   end

   always_ff @(posedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_r <= '0;
      end else if (!cs_n_i && bit_cnt_r < FC_INSTR) begin
         shift_r <= {serial_data_in_i, shift_r[INSTR_BITS-2:1]};
      end
   end

   always_ff @(posedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         conv_s1_r <= 1'b1;
         conv_s2_r <= 1'b1;
      end else begin
         conv_s1_r <= conv_n_i;
         conv_s2_r <= conv_s1_r;
      end
   end

   // The eighth bit completes the instruction; the word is held for the other domain.
   always_ff @(posedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         word_hold_r <= '0;
         hold_conv_r <= 1'b0;
         word_tgl_r <= 1'b0;
      end else if (!cs_n_i && bit_cnt_r == FC_INSTR - FCW'(1)) begin
         word_hold_r <= {serial_data_in_i, shift_r};
         hold_conv_r <= conv_s2_r;
         word_tgl_r <= ~word_tgl_r;
      end
   end

   // Crossings into the conversion clock domain.
   logic tgl_s1_r;
   logic tgl_s2_r;
   logic tgl_s3_r;
   logic pd_s1_r;
   logic pd_s2_r;
   logic pd_prev_r;
   logic word_stb;
   logic pin_pulse_end;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         tgl_s1_r <= 1'b0;
         tgl_s2_r <= 1'b0;
         tgl_s3_r <= 1'b0;
         pd_s1_r <= 1'b0;
         pd_s2_r <= 1'b0;
         pd_prev_r <= 1'b0;
      end else if (ce_i) begin
         tgl_s1_r <= word_tgl_r;
         tgl_s2_r <= tgl_s1_r;
         tgl_s3_r <= tgl_s2_r;
         pd_s1_r <= power_down_pin_i;
         pd_s2_r <= pd_s1_r;
         pd_prev_r <= pd_s2_r;
      end
   end
   assign word_stb = ce_i && (tgl_s2_r != tgl_s3_r);
   assign pin_pulse_end = ce_i && pd_prev_r && !pd_s2_r;

   // Instruction decode.
   logic [INSTR_BITS-1:0] w;
   logic is_test;
   logic is_pwr_up;
   logic is_pwr_dn;
   logic is_sign;
   logic is_acq;
   logic is_conv;

   assign w = word_hold_r;
   assign is_test = word_stb && w[DI_SINGLE] && (w[7:DI_TEST_LO] == OP_TEST_HI);
   assign is_pwr_up = word_stb && (w == OP_PWR_UP);
   assign is_pwr_dn = word_stb && (w == OP_PWR_DN);
   assign is_sign = word_stb && (w[7:1] == OP_SIGN_HI);
   assign is_acq = word_stb && (w[7:2] == OP_ACQ_HI);
   assign is_conv = word_stb && !w[DI_CONV] && !hold_conv_r;
   // Power state.
   logic sw_pd_r;
   logic powered_down;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sw_pd_r <= 1'b0;
      end else if (is_pwr_dn) begin
         sw_pd_r <= 1'b1;
      end else if (is_pwr_up || pin_pulse_end) begin
         sw_pd_r <= 1'b0;
      end
   end

   assign powered_down = pd_s2_r | sw_pd_r;
   assign converter_enable_o = !powered_down;
   // Test mode and the recovery sequence.
   rec_state_t rec_r;
   logic test_mode_r;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rec_r <= rec_idle;
      end else if (word_stb) begin
         unique case (rec_r)
            rec_idle: begin
               rec_r <= (w == OP_RESET) ? rec_reset : rec_idle;
            end
            rec_reset: begin
               rec_r <= (w == OP_TEST_A) ? rec_test_a : rec_idle;
            end
            rec_test_a: begin
               rec_r <= (w == OP_TEST_B) ? rec_test_b : rec_idle;
            end
            rec_test_b: begin
               rec_r <= rec_idle;
            end
            default: begin
               rec_r <= rec_idle;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         test_mode_r <= 1'b0;
      end else if (is_test) begin
         test_mode_r <= 1'b1;
      end else if (word_stb && rec_r == rec_test_b && w == OP_USER) begin
         test_mode_r <= 1'b0;
      end
   end
   assign analog_inputs_oe_o = {NUM_CH{test_mode_r}};
   // Loaded only on a word strobe, when the held word is settled.
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         analog_inputs_o <= '0;
      end else if (is_test || (word_stb && test_mode_r)) begin
         analog_inputs_o <= word_hold_r;
      end
   end

   // Configuration.
   logic sign_on_r;
   logic [1:0] acq_sel_r;
   logic [1:0] res_r;
   logic lsb_first_r;
   logic single_r;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sign_on_r <= SIGN_RST;
         acq_sel_r <= ACQ_SEL_RST;
      end else begin
         if (is_sign) begin
            sign_on_r <= w[0];
         end
         if (is_acq) begin
            acq_sel_r <= w[1:0];
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         res_r <= RES_12;
         lsb_first_r <= 1'b0;
         single_r <= 1'b0;
         selector_output_first_sel_o <= '0;
         selector_output_second_sel_o <= '0;
         selector_output_second_common_o <= 1'b0;
         converter_input_first_positive_o <= 1'b1;
      end else if (is_conv) begin
         res_r <= w[DI_RES_LO +: 2];
         lsb_first_r <= w[DI_LSB_FIRST];
         single_r <= w[DI_SINGLE];
         selector_output_first_sel_o <= '0;
         selector_output_second_sel_o <= '0;
         if (w[DI_SINGLE]) begin
            selector_output_first_sel_o[w[DI_PAIR_LO +: 2] * 2 + w[DI_ODD_POS]] <= 1'b1;
            selector_output_second_common_o <= 1'b1;
            converter_input_first_positive_o <= 1'b1;
         end else begin
            selector_output_first_sel_o[w[DI_PAIR_LO +: 2] * 2] <= 1'b1;
            selector_output_second_sel_o[w[DI_PAIR_LO +: 2]] <= 1'b1;
            selector_output_second_common_o <= 1'b0;
            converter_input_first_positive_o <= !w[DI_ODD_POS];
         end
      end
   end

   always_comb begin
      unique case (res_r)
         RES_8: out_bits_o = LEN_8 + 5'(sign_on_r);
         RES_16: out_bits_o = LEN_16 + 5'(sign_on_r);
         default: out_bits_o = LEN_12 + 5'(sign_on_r);
      endcase
   end

   assign lsb_first_o = lsb_first_r;

   // Conversion sequencing.
   conv_state_t cv_r;
   logic [CNT_BITS-1:0] cnt_r;
   logic [ACQ_BITS-1:0] acq_len;

   always_comb begin
      unique case (acq_sel_r)
         2'h0: acq_len = ACQ_6;
         2'h1: acq_len = ACQ_10;
         2'h2: acq_len = ACQ_18;
         default: acq_len = ACQ_34;
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cv_r <= cv_idle;
         cnt_r <= '0;
      end else if (ce_i) begin
         unique case (cv_r)
            cv_idle: begin
               if (is_conv && !powered_down) begin
                  cv_r <= cv_acq;
                  cnt_r <= CNT_BITS'(acq_len - ACQ_BITS'(1));
               end
            end
            cv_acq: begin
               if (powered_down) begin
                  cv_r <= cv_idle;
               end else if (cnt_r == '0) begin
                  cv_r <= cv_conv;
                  cnt_r <= CONV_LAST;
               end else begin
                  cnt_r <= cnt_r - CNT_BITS'(1);
               end
            end
            cv_conv: begin
               if (powered_down || cnt_r == '0) begin
                  cv_r <= cv_idle;
               end else begin
                  cnt_r <= cnt_r - CNT_BITS'(1);
               end
            end
            default: begin
               cv_r <= cv_idle;
            end
         endcase
      end
   end

   assign busy_o = (cv_r != cv_idle);

   // Result capture with sign handling.
   logic done;
   logic aborting;

   assign done = ce_i && cv_r == cv_conv && cnt_r == '0 && !powered_down;
   assign aborting = ce_i && cv_r != cv_idle && powered_down;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         result_o <= CODE_ZERO;
         result_valid_o <= 1'b0;
         eoc_o <= 1'b0;
      end else if (ce_i) begin
         eoc_o <= done;
         if (done) begin
            result_valid_o <= 1'b1;
            if (single_r && raw_code_i[CODE_BITS-1]) begin
               result_o <= CODE_ZERO;
            end else begin
               result_o <= raw_code_i;
            end
         end else if (aborting) begin
            result_valid_o <= 1'b0;
         end
      end
   end

   // Status word.
   always_comb begin
      status_o = '0;
      status_o[STAT_BUSY] = busy_o;
      status_o[STAT_PDOWN] = powered_down;
      status_o[STAT_SIGN] = sign_on_r;
      status_o[STAT_VALID] = result_valid_o;
      status_o[STAT_TEST] = test_mode_r;
   end
endmodule

/* File: verification/host_link_model.sv */
`timescale 1ns/1ps
module host_link_model (
   output logic sclk_o,
   output logic cs_n_o,
   output logic sdo_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdo_o = 1'b0;
   end
   // Each word is framed by chip select, so framing can never drift.
   task automatic send_word(input logic [7:0] w);
      cs_n_o = 1'b0;
      for (int i = 0; i < 8; i++) begin
         sdo_o = w[i];
         #62.5 sclk_o = 1'b1;
         #62.5 sclk_o = 1'b0;
      end
      #30 cs_n_o = 1'b1;
      sdo_o = ~sdo_o;
   endtask
   // The whole return sequence, ending with a conversion word.
   task automatic recover();
      logic [7:0] seq [8] = '{8'h70, 8'h50, 8'hd0, 8'hf0, 8'h50, 8'hb1, 8'h71, 8'h07};
      foreach (seq[i]) begin
         #400;
         send_word(seq[i]);
      end
   endtask
endmodule

/* File: verification/adc_ctl_checker_properties.sv */
`timescale 1ns/1ps
module adc_ctl_checker (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic power_down_pin_i,
   input wire logic converter_enable_o,
   input wire logic busy_o,
   input wire logic eoc_o,
   input wire logic result_valid_o,
   input wire logic [adc_ctl_pkg::CODE_BITS-1:0] result_o,
   input wire logic [adc_ctl_pkg::STATUS_BITS-1:0] status_o,
   input wire logic [adc_ctl_pkg::NUM_CH-1:0] selector_output_first_sel_o,
   input wire logic [adc_ctl_pkg::NUM_PAIRS-1:0] selector_output_second_sel_o,
   input wire logic selector_output_second_common_o,
   input wire logic converter_input_first_positive_o,
   input wire logic [adc_ctl_pkg::NUM_CH-1:0] analog_inputs_oe_o
);
   import adc_ctl_pkg::*;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   wire [7:0] fs = selector_output_first_sel_o;
   wire [3:0] ss = selector_output_second_sel_o;
   wire cm = selector_output_second_common_o;
   AST_PWR_OR: assert property ((power_down_pin_i && ce_i) [*3] |->
      !converter_enable_o && status_o[STAT_PDOWN])
      else $error("pin power down not in effect or not reported");
   AST_ABORT: assert property ($fell(converter_enable_o) |-> ##[0:2] !busy_o)
      else $error("conversion kept running after power down");
   AST_NO_START: assert property (!converter_enable_o |-> !$rose(busy_o))
      else $error("conversion started while powered down");
   AST_VALID: assert property ($rose(result_valid_o) |-> eoc_o)
      else $error("result valid without end of conversion");
   AST_SE_SIGN: assert property (eoc_o && cm |-> !result_o[CODE_BITS-1])
      else $error("single-ended result with sign set");
   AST_TEST_OE: assert property (analog_inputs_oe_o == {8{status_o[STAT_TEST]}})
      else $error("input drive disagrees with test flag");
   AST_DIFF_MAP: assert property (busy_o && $past(busy_o) && !cm |->
      fs == {1'b0, ss[3], 1'b0, ss[2], 1'b0, ss[1], 1'b0, ss[0]})
      else $error("differential pair routing wrong");
   AST_SE_MAP: assert property (busy_o && $past(busy_o) && cm |->
      converter_input_first_positive_o && ss == 4'h0)
      else $error("single-ended routing wrong");
   AST_ONE_CH: assert property (busy_o && $past(busy_o) |-> $onehot(fs))
      else $error("first selector not one channel");
   cover property (eoc_o && cm);
   cover property ($rose(status_o[STAT_TEST]));
   cover property ($fell(converter_enable_o) && busy_o);
endmodule
bind adc_power_mode_mux_control adc_ctl_checker chk_u (.mclk_i, .rst_i, .ce_i, .power_down_pin_i,
   .converter_enable_o,
   .busy_o, .eoc_o, .result_valid_o, .result_o, .status_o, .selector_output_first_sel_o,
   .selector_output_second_sel_o, .selector_output_second_common_o,
   .converter_input_first_positive_o, .analog_inputs_oe_o);

/* File: verification/adc_power_mode_mux_control_bench.sv */
`timescale 1ns/1ps
module adc_power_mode_mux_control_bench;
   import adc_ctl_pkg::*;
   logic mclk_i = 0, rst_i = 1, ce_i = 1, conv_n_i = 0, power_down_pin_i = 0;
   logic signed [CODE_BITS-1:0] raw_code_i = '0;
   wire sclk_i, cs_n_i, serial_data_in_i, converter_enable_o, busy_o, eoc_o, result_valid_o;
   wire selector_output_second_common_o, converter_input_first_positive_o, lsb_first_o;
   wire [CODE_BITS-1:0] result_o;
   wire [STATUS_BITS-1:0] status_o;
   wire [NUM_CH-1:0] selector_output_first_sel_o, analog_inputs_o, analog_inputs_oe_o;
   wire [NUM_PAIRS-1:0] selector_output_second_sel_o;
   wire [4:0] out_bits_o;
   int error_cnt = 0, compares = 0;
   always #5 mclk_i = ~mclk_i;
   host_link_model host_u (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdo_o(serial_data_in_i));
   adc_power_mode_mux_control #(.CONV_CYCLES(30)) dut_u (.mclk_i, .rst_i, .ce_i, .sclk_i,
      .cs_n_i, .serial_data_in_i, .conv_n_i, .power_down_pin_i, .raw_code_i,
      .converter_enable_o, .busy_o, .eoc_o, .result_valid_o, .result_o, .status_o,
      .selector_output_first_sel_o, .selector_output_second_sel_o,
      .selector_output_second_common_o, .converter_input_first_positive_o,
      .analog_inputs_o, .analog_inputs_oe_o, .out_bits_o, .lsb_first_o);
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   task automatic send(input logic [7:0] w);
      host_u.send_word(w);
      cyc(6);
   endtask
   task automatic wait_eoc();
      for (int i = 0; i < 80 && eoc_o !== 1'b1; i++)
         cyc(1);
      chk("eoc", 16'h1, eoc_o);
   endtask
   task automatic t_reset();
      chk("test flag", 16'h0, status_o[STAT_TEST]);
      chk("enable", 16'h1, converter_enable_o);
      chk("valid", 16'h0, result_valid_o);
      chk("lsb first", 16'h0, lsb_first_o);
      chk("drive enable", 16'h0, analog_inputs_oe_o);
      chk("word length", 16'h0d, out_bits_o);
      $display("reset test done");
   endtask
   task automatic t_power();
      send(OP_PWR_DN);
      chk("enable", 16'h0, converter_enable_o);
      power_down_pin_i = 1;
      cyc(5);
      power_down_pin_i = 0;
      cyc(5);
      chk("enable", 16'h1, converter_enable_o);
      send(OP_PWR_DN);
      send(OP_PWR_UP);
      chk("enable", 16'h1, converter_enable_o);
      power_down_pin_i = 1;
      cyc(5);
      send(OP_PWR_UP);
      chk("enable", 16'h0, converter_enable_o);
      chk("status down", 16'h1, status_o[STAT_PDOWN]);
      power_down_pin_i = 0;
      cyc(5);
      chk("enable", 16'h1, converter_enable_o);
      $display("power test done");
   endtask
   task automatic t_mux();
      raw_code_i = -13'sd100;
      send(8'h07);
      wait_eoc();
      chk("result", 16'h0, result_o);
      chk("first sel", 16'h08, selector_output_first_sel_o);
      chk("common", 16'h1, selector_output_second_common_o);
      chk("positive", 16'h1, converter_input_first_positive_o);
      chk("valid", 16'h1, result_valid_o);
      for (int k = 0; k < 4; k++) begin
         raw_code_i = k[0] ? 13'h0fff : 13'h1000;
         send(8'(8'h02 | (k << 2)));
         wait_eoc();
         chk("result", k[0] ? 16'h0fff : 16'h1000, result_o);
         chk("first sel", 16'(1 << (2 * k)), selector_output_first_sel_o);
         chk("second sel", 16'(1 << k), selector_output_second_sel_o);
         chk("positive", 16'h0, converter_input_first_positive_o);
      end
      send(8'h00);
      wait_eoc();
      chk("positive", 16'h1, converter_input_first_positive_o);
      $display("mux test done");
   endtask
   task automatic t_hold();
      conv_n_i = 1;
      send(8'h07);
      cyc(2);
      chk("busy", 16'h0, busy_o);
      chk("valid", 16'h1, result_valid_o);
      conv_n_i = 0;
      $display("hold test done");
   endtask
   task automatic t_abort();
      host_u.send_word(8'h07);
      cyc(1);
      chk("busy", 16'h1, busy_o);
      power_down_pin_i = 1;
      cyc(5);
      chk("busy", 16'h0, busy_o);
      chk("valid", 16'h0, result_valid_o);
      send(8'hf1);
      chk("test flag", 16'h1, status_o[STAT_TEST]);
      chk("drive enable", 16'hff, analog_inputs_oe_o);
      chk("drive value", 16'hf1, analog_inputs_o);
      power_down_pin_i = 0;
      cyc(5);
      $display("abort test done");
   endtask
   task automatic t_recover();
      send(OP_RESET);
      send(OP_TEST_B);
      send(OP_USER);
      chk("test flag", 16'h1, status_o[STAT_TEST]);
      host_u.recover();
      wait_eoc();
      chk("test flag", 16'h0, status_o[STAT_TEST]);
      chk("drive enable", 16'h0, analog_inputs_oe_o);
      $display("recovery test done");
   endtask
   task automatic t_rerun();
      send(8'ha0);
      chk("word length", 16'h09, out_bits_o);
      chk("lsb first", 16'h1, lsb_first_o);
      ce_i = 0;
      cyc(60);
      chk("busy", 16'h1, busy_o);
      ce_i = 1;
      wait_eoc();
      send(8'hf1);
      chk("test flag", 16'h1, status_o[STAT_TEST]);
      send(OP_PWR_DN);
      chk("enable", 16'h0, converter_enable_o);
      rst_i = 1;
      cyc(5);
      rst_i = 0;
      cyc(2);
      t_reset();
      $display("mid-run reset test done");
   endtask
   initial begin
      cyc(5);
      rst_i = 0;
      cyc(2);
      t_reset();
      t_power();
      t_mux();
      t_hold();
      t_abort();
      t_recover();
      t_rerun();
      report_and_stop();
   end
   initial begin
      #300000;
      error_cnt++;
      $display("unexpected watchdog: expected done, seen hang");
      report_and_stop();
   end
endmodule
